// File: rtl/lst_pkg.sv
// Package for the programmable logic tile: register map, field layouts,
// mode encodings and the fabric-side carriers.
// Assumes a 32-bit AHB-Lite bus with word-aligned register accesses.
package lst_pkg;

    localparam int unsigned LST_NUM_SLICES = 4;
    localparam int unsigned LST_REG_SLICES = 3;
    localparam int unsigned LST_LUT_INPUTS = 4;
    localparam int unsigned LST_LUT_DEPTH = 16;

    // Register byte offsets
    localparam logic [7:0] LST_OFF_LUT0 = 8'h00;
    localparam logic [7:0] LST_OFF_LUT_END = 8'h0C;
    localparam logic [7:0] LST_OFF_MODE = 8'h10;
    localparam logic [7:0] LST_OFF_STORE = 8'h14;
    localparam logic [7:0] LST_OFF_RIPPLE = 8'h18;
    localparam logic [7:0] LST_OFF_STATUS = 8'h1C;

    // Field layouts, one field per slice
    localparam int unsigned LST_MODE_W = 3;
    localparam int unsigned LST_STORE_W = 4;
    localparam int unsigned LST_STORE_ASYNC_BIT = 2;
    localparam int unsigned LST_STORE_SET_BIT = 3;
    localparam int unsigned LST_OP_W = 3;
    localparam int unsigned LST_LUT_HI_BASE = 16;

    // Reset values
    localparam logic [31:0] LST_LUT_RST = 32'h0000_0000;
    localparam logic [11:0] LST_MODE_RST = 12'h000;
    localparam logic [11:0] LST_STORE_RST = 12'h000;
    localparam logic [8:0] LST_RIPPLE_RST = 9'h000;
    localparam logic [31:0] LST_RDATA_RST = 32'h0000_0000;

    localparam logic [1:0] LST_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        LST_MODE_LOGIC = 3'b000,
        LST_MODE_RIPPLE = 3'b001,
        LST_MODE_RAM_SP = 3'b010,
        LST_MODE_RAM_DP = 3'b011,
        LST_MODE_ROM = 3'b100
    } lst_mode_t;

    typedef enum logic [1:0] {
        LST_EDGE_RISE = 2'b00,
        LST_EDGE_FALL = 2'b01,
        LST_EDGE_LATCH = 2'b10
    } lst_edge_t;

    typedef enum logic [2:0] {
        LST_OP_ADD = 3'b000,
        LST_OP_SUB = 3'b001,
        LST_OP_ADDSUB = 3'b010,
        LST_OP_UPCNT = 3'b011,
        LST_OP_DNCNT = 3'b100,
        LST_OP_UDCNT = 3'b101,
        LST_OP_CMP = 3'b110,
        LST_OP_MULT = 3'b111
    } lst_op_t;

    // Twelve routing inputs per slice; the slice clock is core_clk
    typedef struct packed {
        logic [3:0] lutInLo;
        logic [3:0] lutInHi;
        logic auxInLo;
        logic auxInHi;
        logic clkEn;
        logic localSetReset;
    } lst_slice_in_t;

    typedef struct packed {
        logic lutCombOutLo;
        logic lutCombOutHi;
        logic regOutLo;
        logic regOutHi;
        logic mux5Out;
        logic wideMuxOut;
    } lst_slice_out_t;

endpackage

// File: rtl/lst_logic_tile.sv
// One programmable logic tile: four slices of two LUT4s, storage elements in
// slices 0..2, carry chain, wide muxes, distributed RAM/ROM, AHB-Lite config.
// Assumes the fabric drives sliceIn synchronously to core_clk and that a
// single AHB-Lite master issues word transfers.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module lst_logic_tile import lst_pkg::*; #(
    parameter bit HAS_RAM = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire lst_slice_in_t [3:0] sliceIn,
    input wire logic carryInFast,
    input wire logic wideMuxInA,
    input wire logic wideMuxInB,
    output lst_slice_out_t [3:0] sliceOut,
    output logic carryOutFast
);

    function automatic logic isLutAddr(input logic [7:0] addr);
        return (addr <= LST_OFF_LUT_END) && (addr[1:0] == 2'b00);
    endfunction

    logic [31:0] lutTable_q [LST_NUM_SLICES];
    logic [11:0] mode_q;
    logic [11:0] storeCfg_q;
    logic [8:0] rippleOp_q;
    logic busWrPend_q;
    logic [7:0] busAddr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [31:0] rdVal;
    logic [31:0] statusVal;

    logic [4:0] carry;
    logic [3:0] mux5Val;
    logic [3:0] wideVal;
    logic [3:0] wideA;
    logic [3:0] wideB;
    logic [3:0] lutLoVal;
    logic [3:0] lutHiVal;
    logic [3:0] combLo;
    logic [3:0] combHi;
    logic [2:0] regLo;
    logic [2:0] regHi;
    logic [3:0] ramActive;

    logic [3:0] ramWriteAddr;
    logic ramWriteStrobe;
    logic [3:0] ramWriteData;

    wire logic addrPhase = hsel && hready && htrans == LST_HTRANS_NONSEQ;
    wire logic busWr = busWrPend_q;

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busWrPend_q <= 1'b0;
            busAddr_q <= 8'h00;
        end else begin
            busWrPend_q <= addrPhase && hwrite;
            if (addrPhase) begin
                busAddr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    // Read data is sampled in the address phase so it can leave a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata_q <= LST_RDATA_RST;
        end else if (addrPhase && !hwrite) begin
            hrdata_q <= rdVal;
        end else begin
            hrdata_q <= LST_RDATA_RST;
        end
    end

    assign statusVal = {16'h0000, HAS_RAM, carryOutFast, regHi, regLo,
                        combHi, combLo};

    always_comb begin
        rdVal = 32'h0000_0000;
        if (isLutAddr(haddr[7:0])) begin
            rdVal = lutTable_q[haddr[3:2]];
        end else begin
            case (haddr[7:0])
                LST_OFF_MODE: rdVal = {20'h0_0000, mode_q};
                LST_OFF_STORE: rdVal = {20'h0_0000, storeCfg_q};
                LST_OFF_RIPPLE: rdVal = {23'h00_0000, rippleOp_q};
                LST_OFF_STATUS: rdVal = statusVal;
                default: rdVal = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= LST_MODE_RST;
            storeCfg_q <= LST_STORE_RST;
            rippleOp_q <= LST_RIPPLE_RST;
        end else if (busWr) begin
            case (busAddr_q)
                LST_OFF_MODE: mode_q <= hwdata[11:0];
                LST_OFF_STORE: storeCfg_q <= hwdata[11:0];
                LST_OFF_RIPPLE: rippleOp_q <= hwdata[8:0];
                default: ;
            endcase
        end
    end

    // Slice 1 drives the memory address and write control
    assign ramWriteAddr = sliceIn[1].lutInLo;
    assign ramWriteStrobe = sliceIn[1].localSetReset;
    assign ramWriteData = {sliceIn[2].auxInHi, sliceIn[2].auxInLo,
                           sliceIn[0].auxInHi, sliceIn[0].auxInLo};

    // Truth tables double as RAM cells; a bus write wins over a RAM write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < LST_NUM_SLICES; i++) begin
                lutTable_q[i] <= LST_LUT_RST;
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (ramActive[2*k] && ramWriteStrobe) begin
                    lutTable_q[2*k][{1'b0, ramWriteAddr}] <=
                        ramWriteData[2*k];
                    lutTable_q[2*k][{1'b1, ramWriteAddr}] <=
                        ramWriteData[2*k+1];
                end
            end
            for (int i = 0; i < LST_NUM_SLICES; i++) begin
                if (busWr && isLutAddr(busAddr_q) &&
                    busAddr_q[3:2] == 2'(i)) begin
                    lutTable_q[i] <= hwdata;
                end
            end
        end
    end

    // Wide mux tree: LUT6 in slices 0 and 2, LUT7 in slice 1; slice 3
    // selects between wideMuxInA and wideMuxInB, both from outside the tile
    assign wideA = {wideMuxInA, mux5Val[2], wideVal[0], mux5Val[0]};
    assign wideB = {wideMuxInB, mux5Val[3], wideVal[2], mux5Val[1]};
    assign carry[0] = carryInFast;
    assign carryOutFast = carry[3];

    for (genvar s = 0; s < LST_NUM_SLICES; s++) begin : gSlice
        lst_mode_t mode;
        lst_op_t op;
        logic [3:0] idxLo;
        logic [3:0] idxHi;
        logic [1:0] opA;
        logic [1:0] opB;
        logic [1:0] sum;
        logic [1:0] q;
        logic co;
        logic lessEq;
        logic ripple;

        assign mode = lst_mode_t'(mode_q[LST_MODE_W*s +: LST_MODE_W]);
        assign op = lst_op_t'(rippleOp_q[LST_OP_W*s +: LST_OP_W]);
        assign ripple = (s < LST_REG_SLICES) && mode == LST_MODE_RIPPLE;
        assign ramActive[s] = HAS_RAM && (s == 0 || s == 2) &&
            (mode == LST_MODE_RAM_SP || mode == LST_MODE_RAM_DP);

        // Single-port reads follow the write address; the dual-port
        // companion reads on its own LUT inputs
        assign idxLo = (ramActive[s] && mode == LST_MODE_RAM_SP) ?
            ramWriteAddr : sliceIn[s].lutInLo;
        assign idxHi = (ramActive[s] && mode == LST_MODE_RAM_SP) ?
            ramWriteAddr : sliceIn[s].lutInHi;
        assign lutLoVal[s] = lutTable_q[s][{1'b0, idxLo}];
        assign lutHiVal[s] = lutTable_q[s][{1'b1, idxHi}];
        assign mux5Val[s] = sliceIn[s].auxInLo ? lutHiVal[s] : lutLoVal[s];
        assign wideVal[s] = sliceIn[s].auxInHi ? wideB[s] : wideA[s];

        assign opA = {sliceIn[s].lutInHi[0], sliceIn[s].lutInLo[0]};
        assign opB = {sliceIn[s].lutInHi[1], sliceIn[s].lutInLo[1]};
        if (s < LST_REG_SLICES) begin : gQ
            assign q = {regHi[s], regLo[s]};
        end else begin : gNoQ
            assign q = 2'b00;
        end

        // Carry is a not-borrow for subtract and compare, so the chain
        // bottom must be tied high for those
        always_comb begin
            sum = 2'b00;
            co = carry[s];
            lessEq = 1'b0;
            if (ripple) begin
                case (op)
                    LST_OP_ADD: {co, sum} = 3'(opA + opB + carry[s]);
                    LST_OP_SUB: {co, sum} = 3'(opA + {1'b0, ~opB} + carry[s]);
                    LST_OP_ADDSUB: begin
                        if (sliceIn[s].auxInLo) begin
                            {co, sum} = 3'(opA + {1'b0, ~opB} + carry[s]);
                        end else begin
                            {co, sum} = 3'(opA + opB + carry[s]);
                        end
                    end
                    LST_OP_UPCNT: begin
                        sum = 2'(q + carry[s]);
                        co = (&q) && carry[s];
                    end
                    LST_OP_DNCNT: begin
                        sum = 2'(q - carry[s]);
                        co = (q == 2'b00) && carry[s];
                    end
                    LST_OP_UDCNT: begin
                        if (sliceIn[s].auxInHi) begin
                            sum = opA;
                            co = 1'b0;
                        end else if (sliceIn[s].auxInLo) begin
                            sum = 2'(q - carry[s]);
                            co = (q == 2'b00) && carry[s];
                        end else begin
                            sum = 2'(q + carry[s]);
                            co = (&q) && carry[s];
                        end
                    end
                    LST_OP_CMP: begin
                        co = opA > opB || (opA == opB && carry[s]);
                        sum = {opA != opB, co};
                        lessEq = opA <= opB;
                    end
                    LST_OP_MULT: begin
                        {co, sum} = 3'(opB + (opA & {2{sliceIn[s].auxInLo}})
                                       + carry[s]);
                    end
                    default: sum = 2'b00;
                endcase
            end
        end

        assign carry[s+1] = co;
        assign combLo[s] = ripple ? sum[0] : lutLoVal[s];
        assign combHi[s] = ripple ? sum[1] : lutHiVal[s];

        if (s < LST_REG_SLICES) begin : gStore
            logic [LST_STORE_W-1:0] cfg;
            lst_edge_t edgeMode;
            logic local_set_reset;
            logic asyncSet;
            logic asyncClr;
            logic syncLsr;
            logic setVal;
            logic [1:0] d;
            logic [1:0] rise_q;
            logic [1:0] fall_q;
            logic [1:0] latch_q;
            logic [1:0] stored;

            assign cfg = storeCfg_q[LST_STORE_W*s +: LST_STORE_W];
            assign edgeMode = lst_edge_t'(cfg[1:0]);
            assign setVal = cfg[LST_STORE_SET_BIT];
            // A strobe used as RAM write enable must not disturb the flops
            assign local_set_reset = sliceIn[s].localSetReset && !(s == 1 &&
                (ramActive[0] || ramActive[2]));
            assign asyncSet = local_set_reset && cfg[LST_STORE_ASYNC_BIT] && setVal;
            assign asyncClr = local_set_reset && cfg[LST_STORE_ASYNC_BIT] && !setVal;
            assign syncLsr = local_set_reset && !cfg[LST_STORE_ASYNC_BIT];
            assign d = {combHi[s], combLo[s]};

            for (genvar b = 0; b < 2; b++) begin : gBit
                always_ff @(posedge core_clk or posedge asyncSet
                            or posedge asyncClr) begin
                    if (asyncClr) begin
                        rise_q[b] <= 1'b0;
                    end else if (asyncSet) begin
                        rise_q[b] <= 1'b1;
                    end else if (rst) begin
                        rise_q[b] <= 1'b0;
                    end else if (syncLsr) begin
                        rise_q[b] <= setVal;
                    end else if (sliceIn[s].clkEn) begin
                        rise_q[b] <= d[b];
                    end
                end

                always_ff @(negedge core_clk or posedge asyncSet
                            or posedge asyncClr) begin
                    if (asyncClr) begin
                        fall_q[b] <= 1'b0;
                    end else if (asyncSet) begin
                        fall_q[b] <= 1'b1;
                    end else if (rst) begin
                        fall_q[b] <= 1'b0;
                    end else if (syncLsr) begin
                        fall_q[b] <= setVal;
                    end else if (sliceIn[s].clkEn) begin
                        fall_q[b] <= d[b];
                    end
                end

                // Transparent while the clock is high and enabled
                always_latch begin
                    if (asyncClr || rst) begin
                        latch_q[b] <= 1'b0;
                    end else if (asyncSet) begin
                        latch_q[b] <= 1'b1;
                    end else if (core_clk && syncLsr) begin
                        latch_q[b] <= setVal;
                    end else if (core_clk && sliceIn[s].clkEn) begin
                        latch_q[b] <= d[b];
                    end
                end

                assign stored[b] = edgeMode == LST_EDGE_FALL ? fall_q[b] :
                    edgeMode == LST_EDGE_LATCH ? latch_q[b] :
                    rise_q[b];
            end

            assign regLo[s] = stored[0];
            assign regHi[s] = stored[1];
            assign sliceOut[s].regOutLo = stored[0];
            assign sliceOut[s].regOutHi = stored[1];
        end else begin : gNoStore
            assign sliceOut[s].regOutLo = 1'b0;
            assign sliceOut[s].regOutHi = 1'b0;
        end

        assign sliceOut[s].lutCombOutLo = combLo[s];
        assign sliceOut[s].lutCombOutHi = combHi[s];
        assign sliceOut[s].mux5Out = (ripple && op == LST_OP_CMP) ?
            lessEq : mux5Val[s];
        assign sliceOut[s].wideMuxOut = wideVal[s];
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;

endmodule

`default_nettype wire

// File: testbench/lst_fabric_model.sv
// Fabric model: routing and neighbouring tiles around one logic tile.
// Assumes the bench hands it the next fabric values; it launches them just
// after each rising edge, as registered routing in the fabric would.
`timescale 1ns/1ps
`default_nettype none
module lst_fabric_model import lst_pkg::*; (
    input wire logic core_clk,
    input wire lst_slice_in_t [3:0] nextIn,
    input wire logic [2:0] nextNeigh,
    output var lst_slice_in_t [3:0] sliceIn,
    output var logic carryInFast,
    output var logic wideMuxInA,
    output var logic wideMuxInB
);
    initial begin
        sliceIn = '0;
        {carryInFast, wideMuxInA, wideMuxInB} = 3'h0;
    end
    // Registered launch keeps every change clear of the sampling edge
    always @(posedge core_clk) begin
        sliceIn <= nextIn;
        {carryInFast, wideMuxInA, wideMuxInB} <= nextNeigh;
    end
endmodule
`default_nettype wire

// File: testbench/lst_tile_monitor.sv
// Checker beside the logic tile: bus timing, status read, slice 3 muxes,
// slice 0 hold. Assumes only the tile's own ports are visible.
`timescale 1ns/1ps
`default_nettype none
module lst_tile_monitor import lst_pkg::*; #(
    parameter bit HAS_RAM = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire lst_slice_in_t [3:0] sliceIn,
    input wire logic wideMuxInA,
    input wire logic wideMuxInB,
    input wire lst_slice_out_t [3:0] sliceOut,
    input wire logic carryOutFast
);
    logic take;
    logic readPhase_q;
    logic [15:0] statusNow;
    assign take = hsel && hready && htrans == LST_HTRANS_NONSEQ;
    always_comb begin
        statusNow = {HAS_RAM, carryOutFast, 14'h0000};
        for (int s = 0; s < 4; s++) begin
            statusNow[s] = sliceOut[s].lutCombOutLo;
            statusNow[4 + s] = sliceOut[s].lutCombOutHi;
        end
        for (int s = 0; s < 3; s++) begin
            statusNow[8 + s] = sliceOut[s].regOutLo;
            statusNow[11 + s] = sliceOut[s].regOutHi;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            readPhase_q <= 1'b0;
        end else begin
            readPhase_q <= take && !hwrite;
        end
    end
    default clocking mcb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_resp_always_okay: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    a_ready_after_reset: assert property (!rst |=> hreadyout == 1'b1)
        else $error("hreadyout low outside reset");
    a_rdata_idle_zero: assert property (
        !readPhase_q |-> hrdata == 32'h0000_0000)
        else $error("hrdata not zero outside a read data phase");
    a_status_read_back: assert property (
        take && !hwrite && haddr[7:0] == LST_OFF_STATUS
        |=> hrdata[15:0] == $past(statusNow))
        else $error("status read differs from slice outputs");
    a_slice3_no_regs: assert property (
        sliceOut[3].regOutLo == 1'b0 && sliceOut[3].regOutHi == 1'b0)
        else $error("slice 3 drives register outputs");
    a_lut5_mux_select: assert property (
        sliceOut[3].mux5Out == (sliceIn[3].auxInLo ?
        sliceOut[3].lutCombOutHi : sliceOut[3].lutCombOutLo))
        else $error("slice 3 LUT5 mux wrong");
    a_wide_mux_ports: assert property (
        sliceOut[3].wideMuxOut ==
        (sliceIn[3].auxInHi ? wideMuxInB : wideMuxInA))
        else $error("slice 3 wide mux wrong");
    a_hold_without_enable: assert property (
        (!sliceIn[0].clkEn && !sliceIn[0].localSetReset) [*2]
        |-> $stable(sliceOut[0].regOutLo) && $stable(sliceOut[0].regOutHi))
        else $error("slice 0 flops moved without enable");
    c_bus_read: cover property (take && !hwrite);
    c_bus_write: cover property (take && hwrite);
    c_carry_out: cover property (carryOutFast);
endmodule
bind lst_logic_tile lst_tile_monitor #(.HAS_RAM(HAS_RAM)) u_mon (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sliceIn(sliceIn),
    .wideMuxInA(wideMuxInA), .wideMuxInB(wideMuxInB),
    .sliceOut(sliceOut), .carryOutFast(carryOutFast));
`default_nettype wire

// File: testbench/lst_logic_tile_test.sv
// Self-checking bench for the logic tile: bus, LUTs, storage, ripple, RAM.
// Assumes one bus master here and the fabric model on the routing side.
`timescale 1ns/1ps
`default_nettype none
module lst_logic_tile_test import lst_pkg::*; ;
    logic core_clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic carryInFast, wideMuxInA, wideMuxInB, carryOutFast;
    logic [2:0] nb, nextNeigh;
    lst_slice_in_t [3:0] fin, nextIn, sliceIn;
    lst_slice_out_t [3:0] sliceOut;
    logic [31:0] tt [4];
    logic [3:0] ram [16];
    logic [31:0] q;
    logic [5:0] a6, b6;
    logic [6:0] sum;
    logic [5:0] h;
    logic [3:0] rd;
    logic w;
    int miscompares, checkCount;

    lst_logic_tile #(.HAS_RAM(1'b1)) uut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sliceIn(sliceIn), .carryInFast(carryInFast),
        .wideMuxInA(wideMuxInA), .wideMuxInB(wideMuxInB),
        .sliceOut(sliceOut), .carryOutFast(carryOutFast));
    lst_fabric_model fab (
        .core_clk(core_clk), .nextIn(nextIn), .nextNeigh(nextNeigh),
        .sliceIn(sliceIn), .carryInFast(carryInFast),
        .wideMuxInA(wideMuxInA), .wideMuxInB(wideMuxInB));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Single word transfer; the wait ends only on hready or the watchdog
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= LST_HTRANS_NONSEQ;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Fabric values land one edge after hand-over; look d ns after that
    task automatic apply(input realtime d);
        @(posedge core_clk);
        nextIn <= fin;
        nextNeigh <= nb;
        @(posedge core_clk);
        #d;
    endtask

    task automatic setCtl(input logic en, input logic sr);
        for (int s = 0; s < 4; s++) begin
            fin[s].clkEn = en;
            fin[s].localSetReset = sr;
        end
    endtask

    task automatic regs(input logic [1:0] v);
        for (int s = 0; s < 3; s++) begin
            check({sliceOut[s].regOutHi, sliceOut[s].regOutLo}, v);
        end
    endtask

    function automatic logic lut(input int s, input logic hi);
        lut = hi ? tt[s][16 + fin[s].lutInHi] : tt[s][fin[s].lutInLo];
    endfunction

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        giveVerdict();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        fin = '0;
        nb = 3'h0;
        nextIn = '0;
        nextNeigh = 3'h0;
        miscompares = 0;
        checkCount = 0;
        void'($urandom(32'h0000_8b51));
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a <= 8'h40; a += 4) begin
            bus(1'b0, 8'(a), 32'h0, q);
            check(q, a == 8'h1C ? 32'h0000_8000 : 32'h0);
        end
        bus(1'b1, 8'h40, 32'hFFFF_FFFF, q);
        bus(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0);
        for (int s = 0; s < 4; s++) begin
            tt[s] = $urandom;
            bus(1'b1, 8'(4 * s), tt[s], q);
            bus(1'b0, 8'(4 * s), 32'h0, q);
            check(q, tt[s]);
        end
        for (int k = 0; k < 16; k++) begin
            fin = 48'({$urandom, $urandom});
            nb = 3'($urandom);
            apply(6.0);
            for (int s = 0; s < 4; s++) begin
                check(sliceOut[s].lutCombOutLo, lut(s, 1'b0));
                check(sliceOut[s].lutCombOutHi, lut(s, 1'b1));
                check(sliceOut[s].mux5Out, lut(s, fin[s].auxInLo));
            end
            w = fin[0].auxInHi ? lut(1, fin[1].auxInLo) :
                lut(0, fin[0].auxInLo);
            check(sliceOut[0].wideMuxOut, w);
            w = fin[2].auxInHi ? lut(3, fin[3].auxInLo) :
                lut(2, fin[2].auxInLo);
            check(sliceOut[2].wideMuxOut, w);
        end
        // Rise, fall and latch each show new data at a different moment
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, LST_OFF_STORE, 32'(m) * 32'h0000_0111, q);
            for (int k = 0; k < 4; k++) begin
                fin = 48'({$urandom, $urandom});
                setCtl(1'b1, 1'b0);
                apply(m == 0 ? 6.0 : (m == 1 ? 3.5 : 1.0));
                for (int s = 0; s < 3; s++) begin
                    check(sliceOut[s].regOutLo, lut(s, 1'b0));
                    check(sliceOut[s].regOutHi, lut(s, 1'b1));
                    h[2 * s +: 2] = {lut(s, 1'b1), lut(s, 1'b0)};
                end
            end
        end
        bus(1'b1, LST_OFF_STORE, 32'h0, q);
        fin = 48'({$urandom, $urandom});
        setCtl(1'b0, 1'b0);
        apply(6.0);
        for (int s = 0; s < 3; s++) begin
            check({sliceOut[s].regOutHi, sliceOut[s].regOutLo},
                  h[2 * s +: 2]);
        end
        bus(1'b1, LST_OFF_STORE, 32'h0000_0888, q);
        setCtl(1'b0, 1'b1);
        apply(6.0);
        regs(2'b11);
        // Strobe must be low before async clear is armed, else it clears
        setCtl(1'b0, 1'b0);
        apply(6.0);
        bus(1'b1, LST_OFF_STORE, 32'h0000_0444, q);
        regs(2'b11);
        setCtl(1'b0, 1'b1);
        apply(1.0);
        regs(2'b00);
        bus(1'b1, LST_OFF_MODE, 32'h0000_0049, q);
        // Every third pass compares; its last carry equals the subtract's
        for (int k = 0; k < 24; k++) begin
            bus(1'b1, LST_OFF_RIPPLE, k % 3 == 2 ? 32'h0000_01B6 :
                32'h0000_0049 * 32'(k % 3), q);
            fin = 48'({$urandom, $urandom});
            nb = 3'($urandom);
            apply(6.0);
            for (int s = 0; s < 3; s++) begin
                a6[2 * s +: 2] = {fin[s].lutInHi[0], fin[s].lutInLo[0]};
                b6[2 * s +: 2] = {fin[s].lutInHi[1], fin[s].lutInLo[1]};
            end
            for (int s = 0; s < 3 && k % 3 == 2; s++) begin
                rd = {a6[2 * s +: 2], b6[2 * s +: 2]};
                check(sliceOut[s].lutCombOutHi, rd[3:2] != rd[1:0]);
                check(sliceOut[s].mux5Out, rd[3:2] <= rd[1:0]);
            end
            b6 = k % 3 != 0 ? ~b6 : b6;
            sum = a6 + b6 + nb[2];
            for (int s = 0; s < 3 && k % 3 < 2; s++) begin
                check(sliceOut[s].lutCombOutLo, sum[2 * s]);
                check(sliceOut[s].lutCombOutHi, sum[2 * s + 1]);
            end
            check(carryOutFast, sum[6]);
        end
        bus(1'b1, LST_OFF_MODE, 32'h0000_0082, q);
        fin = '0;
        for (int a = 0; a < 16; a++) begin
            ram[a] = 4'($urandom);
            fin[1].lutInLo = 4'(a);
            fin[1].localSetReset = 1'b1;
            {fin[2].auxInHi, fin[2].auxInLo} = ram[a][3:2];
            {fin[0].auxInHi, fin[0].auxInLo} = ram[a][1:0];
            apply(6.0);
        end
        // Fresh data with the strobe low must leave the memory alone
        for (int a = 15; a >= 0; a--) begin
            fin = 48'({$urandom, $urandom});
            setCtl(1'b0, 1'b0);
            fin[1].lutInLo = 4'(a);
            apply(6.0);
            rd = {sliceOut[2].lutCombOutHi, sliceOut[2].lutCombOutLo,
                  sliceOut[0].lutCombOutHi, sliceOut[0].lutCombOutLo};
            check(rd, ram[a]);
        end
        giveVerdict();
    end
endmodule
`default_nettype wire
